// ### image_mapper.sv
// Digital I/O process image mapper with an APB register port.
// Overview of operation.
// Software describes the node by writing one kind code per slot.
// It also writes how many words of analog data lead each image.
// The digital area of each image starts right after those analog words.
// Slots are then packed one after the other, each by its own bit width.
// A slot of kind none takes no room in either image.
// The input image is rebuilt from the field pins on every clock edge.
// The output image is a plain register file written by the bus master.
// Channel drives follow the output image one clock edge after a write.
//
// Address map of the register port.
// Input image words sit at the input base, four bytes apart.
// Output image words sit at the output base, four bytes apart.
// Slot kind codes sit at the kind base, one slot per word.
// The two analog word counts sit at their own fixed addresses.
// Only the low sixteen bits of a bus word carry image data.
// Byte lane 0 holds the image byte at the lower address.
// Byte lane 1 holds the image byte at the higher address.
// Lanes 2 and 3 are ignored on writes and read back as zero.
//
// Limitations that a user must know.
// Bits that would fall beyond the last image word are dropped silently.
// Writes to the input image are ignored and answer without an error.
// Unaligned or unmapped addresses answer with a slave error.
// A kind code above the last defined kind behaves like an empty slot.
// Changing a kind or an analog count moves every later slot at once.
// Software should therefore set up the node before driving outputs.
//
// The APB register port and the address map were decided locally.
`include "image_mapper_defs.svh"
`default_nettype none
module image_mapper
   import image_mapper_pkg::*;
#(
   parameter int NUM_SLOTS = 8,
   parameter int IMG_WORDS = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire field_pins_type field_in [NUM_SLOTS],
   output logic [7:0] channel_out [NUM_SLOTS],
   output logic [IMG_WORDS*16-1:0] onboard_program_image_in,
   output logic [IMG_WORDS*16-1:0] onboard_program_image_out
);
   localparam int IMG_BITS = IMG_WORDS * `WORD_BITS;

   // The three functions below describe each kind of module.
   // They are used by the placement logic for every slot.
   // Keeping them in one place means a new kind needs one edit per table.
   // Widths are in bits, so a two channel module takes two bits.
   // Modules are not padded to bytes inside the digital area.

   // Bits a module kind occupies in the input image.
   function automatic int in_width(input slot_kind_type kind);
      case (kind)
         KIND_DI2, KIND_DI1_DIAG, KIND_DO1_IN: in_width = 2;
         KIND_DI4, KIND_DI2_DIAG, KIND_DI2_ACK: in_width = 4;
         KIND_DI8: in_width = 8;
         default: in_width = 0;
      endcase
   endfunction : in_width

   // Bits a module kind occupies in the output image.
   function automatic int out_width(input slot_kind_type kind);
      case (kind)
         KIND_DO1_IN, KIND_DO2: out_width = 2;
         KIND_DO4, KIND_DI2_ACK: out_width = 4;
         KIND_DO8: out_width = 8;
         default: out_width = 0;
      endcase
   endfunction : out_width

   // Mask of output bits that really drive a channel.
   function automatic logic [7:0] drive_mask(input slot_kind_type kind);
      case (kind)
         KIND_DO1_IN: drive_mask = 8'h01;
         KIND_DO2: drive_mask = 8'h03;
         KIND_DO4: drive_mask = 8'h0F;
         KIND_DO8: drive_mask = 8'hFF;
         default: drive_mask = 8'h00;
      endcase
   endfunction : drive_mask

   slot_kind_type kind_r [NUM_SLOTS];
   logic [7:0] analog_in_r;
   logic [7:0] analog_out_r;
   logic [IMG_BITS-1:0] in_img_r;
   logic [IMG_BITS-1:0] in_img_nxt;
   logic [IMG_BITS-1:0] out_img_r;
   logic [1:0] blocked_r [NUM_SLOTS];
   logic [1:0] blocked_nxt [NUM_SLOTS];
   logic [7:0] channel_nxt [NUM_SLOTS];
   logic [15:0] rd_word;

   // The address is split into a region nibble and a word index.
   // The region picks the input image, the output image or the kind table.
   // The index picks one word within that region.
   // The two analog counts are matched on their full address instead.
   // A hit also demands an aligned address and an index inside the region.

   // Address decode of the APB request.
   wire logic [3:0] region = paddr[`REGION_FIELD];
   wire logic [5:0] index = paddr[`INDEX_FIELD];
   wire logic word_ok = (32'(index) < IMG_WORDS) && (paddr[1:0] == 2'b00);
   wire logic hit_in = (region == `IN_IMG_BASE >> 8) && word_ok;
   wire logic hit_out = (region == `OUT_IMG_BASE >> 8) && word_ok;
   wire logic hit_kind = (region == `SLOT_KIND_BASE >> 8) && (32'(index) < NUM_SLOTS) && (paddr[1:0] == 2'b00);
   wire logic hit_ain = (paddr == `ANALOG_IN_OFS);
   wire logic hit_aout = (paddr == `ANALOG_OUT_OFS);
   wire logic mapped = hit_in || hit_out || hit_kind || hit_ain || hit_aout;
   wire logic access_wr = psel && penable && pwrite && mapped;

   // Zero wait states; unmapped addresses answer with an error.
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = {16'h0000, rd_word};

   // Image placement: accumulate sizes slot by slot behind the analog data.
   // Two running offsets walk through the slots, one per image.
   // Each offset starts at the first bit after the analog words.
   // For every slot the output field is gathered first.
   // That field feeds both the channel drives and the acknowledge logic.
   // The input field is then built from the field pins and scattered.
   // Both offsets then advance by the widths of the current slot.
   // Because the walk is combinational, a change of layout acts at once.
   // The acknowledge module keeps a blocked flag for each of its channels.
   // A fault on a channel sets its flag and forces its state bit to zero.
   // The flag is shown in the diagnostic bit of that channel.
   // Once the fault has gone, the flag stays set until acknowledged.
   // The acknowledge bit is a level in the output image, not an edge.
   // A fault that is still present wins over a standing acknowledge.
   // This keeps the input off while the wire is still broken.
   always_comb begin
      int ofs_i;
      int ofs_o;
      logic [7:0] fin;
      logic [7:0] fo;
      logic [7:0] st;
      ofs_i = 32'(analog_in_r) * `WORD_BITS;
      ofs_o = 32'(analog_out_r) * `WORD_BITS;
      fin = 8'h00;
      fo = 8'h00;
      st = 8'h00;
      in_img_nxt = '0;
      for (int s = 0; s < NUM_SLOTS; s++) begin
         fo = 8'h00;
         for (int k = 0; k < `FIELD_BITS; k++) begin
            if (k < out_width(kind_r[s]) && ofs_o + k < IMG_BITS) begin
               fo[k] = out_img_r[ofs_o + k];
            end
         end
         channel_nxt[s] = fo & drive_mask(kind_r[s]);
         blocked_nxt[s] = blocked_r[s];
         if (kind_r[s] == KIND_DI2_ACK) begin
            for (int c = 0; c < 2; c++) begin
               if (field_in[s].fault[c]) begin
                  blocked_nxt[s][c] = 1'b1;
               end else if (fo[c + 2]) begin
                  blocked_nxt[s][c] = 1'b0;
               end
            end
         end else begin
            blocked_nxt[s] = 2'b00;
         end
         st = field_in[s].state;
         fin = 8'h00;
         case (kind_r[s])
            KIND_DI2: fin = {6'h00, st[1:0]};
            KIND_DI4: fin = {4'h0, st[3:0]};
            KIND_DI8: fin = st;
            KIND_DI1_DIAG: fin = {6'h00, field_in[s].fault[0], st[0]};
            KIND_DI2_DIAG: fin = {4'h0, field_in[s].fault, st[1:0]};
            KIND_DI2_ACK: fin = {4'h0, blocked_r[s], st[1:0] & ~blocked_r[s]};
            KIND_DO1_IN: fin = {7'h00, field_in[s].manual};
            default: fin = 8'h00;
         endcase
         for (int k = 0; k < `FIELD_BITS; k++) begin
            if (k < in_width(kind_r[s]) && ofs_i + k < IMG_BITS) begin
               in_img_nxt[ofs_i + k] = fin[k];
            end
         end
         ofs_i = ofs_i + in_width(kind_r[s]);
         ofs_o = ofs_o + out_width(kind_r[s]);
      end
   end

   // Read word selection, low byte at the lower address.
   always_comb begin
      rd_word = 16'h0000;
      if (hit_in) begin
         rd_word = in_img_r[index * `WORD_BITS +: `WORD_BITS];
      end else if (hit_out) begin
         rd_word = out_img_r[index * `WORD_BITS +: `WORD_BITS];
      end else if (hit_kind) begin
         rd_word = {12'h000, kind_r[index[2:0]]};
      end else if (hit_ain) begin
         rd_word = {8'h00, analog_in_r};
      end else if (hit_aout) begin
         rd_word = {8'h00, analog_out_r};
      end
   end

   // Image and channel state flops.
   // The input image is registered so that a bus read sees settled data.
   // A change on the field pins therefore shows one edge later on the bus, two edges later for the fault pins of a KIND_DI2_ACK slot.
   // Channel drives are registered so that the pins never glitch.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_img_r <= '0;
         for (int s = 0; s < NUM_SLOTS; s++) begin
            blocked_r[s] <= 2'b00;
            channel_out[s] <= 8'h00;
         end
      end else begin
         in_img_r <= in_img_nxt;
         for (int s = 0; s < NUM_SLOTS; s++) begin
            blocked_r[s] <= blocked_nxt[s];
            channel_out[s] <= channel_nxt[s];
         end
      end
   end

   // Register writes taken at the access edge; byte lanes 0 and 1 only.
   // Each image byte has its own strobe, so one byte can change alone.
   // The kind table and the analog counts use byte lane 0 only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_img_r <= '0;
         analog_in_r <= `ANALOG_RESET;
         analog_out_r <= `ANALOG_RESET;
         for (int s = 0; s < NUM_SLOTS; s++) begin
            kind_r[s] <= KIND_NONE;
         end
      end else if (access_wr) begin
         if (hit_out) begin
            for (int b = 0; b < 2; b++) begin
               if (pstrb[b]) begin
                  out_img_r[index * `WORD_BITS + b * 8 +: 8] <= pwdata[b * 8 +: 8];
               end
            end
         end else if (hit_kind && pstrb[0]) begin
            kind_r[index[2:0]] <= slot_kind_type'(pwdata[3:0]);
         end else if (hit_ain && pstrb[0]) begin
            analog_in_r <= pwdata[7:0];
         end else if (hit_aout && pstrb[0]) begin
            analog_out_r <= pwdata[7:0];
         end
      end
   end

   // The program side sees the very same images.
   // Both views come from the same flops, so they can never disagree.
   assign onboard_program_image_in = in_img_r;
   assign onboard_program_image_out = out_img_r;
endmodule : image_mapper
`default_nettype wire

// ### image_mapper_defs.svh
// Register offsets, reset values and sizes for the process image mapper.
`ifndef IMAGE_MAPPER_DEFS_SVH
`define IMAGE_MAPPER_DEFS_SVH
`define IN_IMG_BASE 12'h000
`define OUT_IMG_BASE 12'h100
`define SLOT_KIND_BASE 12'h200
`define ANALOG_IN_OFS 12'h300
`define ANALOG_OUT_OFS 12'h304
`define REGION_FIELD 11:8
`define INDEX_FIELD 7:2
`define WORD_BITS 16
`define FIELD_BITS 8
`define ANALOG_RESET 8'h00
`define IMG_RESET 16'h0000
`endif

// ### image_mapper_pkg.sv
// Types shared by the process image mapper.
`default_nettype none
package image_mapper_pkg;
   // Kind of I/O module placed in one slot of the node.
   typedef enum logic [3:0] {
      KIND_NONE = 4'b0000,
      KIND_DI2 = 4'b0001,
      KIND_DI4 = 4'b0010,
      KIND_DI8 = 4'b0011,
      KIND_DI1_DIAG = 4'b0100,
      KIND_DI2_DIAG = 4'b0101,
      KIND_DI2_ACK = 4'b0110,
      KIND_DO1_IN = 4'b0111,
      KIND_DO2 = 4'b1000,
      KIND_DO4 = 4'b1001,
      KIND_DO8 = 4'b1010
   } slot_kind_type;

   // Field-side signals of one slot.
   typedef struct packed {
      logic [7:0] state;
      logic [1:0] fault;
      logic manual;
   } field_pins_type;
endpackage : image_mapper_pkg
`default_nettype wire

// ### image_mapper_props.sv
// Checker of the APB side of the image mapper.
`default_nettype none
module image_mapper_props #(parameter int NUM_SLOTS = 8, parameter int IMG_WORDS = 16) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [IMG_WORDS*16-1:0] onboard_program_image_in,
   input wire logic [IMG_WORDS*16-1:0] onboard_program_image_out
);
   // Access phase of a transfer, and its read form.
   wire acc = psel && penable;
   wire rd = acc && !pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence low_wr_s;
      acc && pwrite && paddr == 12'h100 && pstrb == 4'h1;
   endsequence
   zero_wait_a: assert property (acc |-> pready) else $error("wait state");
   upper_zero_a: assert property (rd |-> !prdata[31:16]) else $error("upper half set");
   unaligned_a: assert property (acc && paddr[1:0] |-> pslverr) else $error("unaligned");
   image_ok_a: assert property (acc && !paddr[11:8] && !paddr[1:0] && paddr[7:2] < IMG_WORDS |-> !pslverr)
      else $error("image error");
   in_mirror_a: assert property (rd && paddr == 12'h004 |-> prdata[15:0] == onboard_program_image_in[31:16])
      else $error("input image");
   out_mirror_a: assert property (rd && paddr == 12'h100 |-> prdata[15:0] == onboard_program_image_out[15:0])
      else $error("output image");
   low_byte_a: assert property (low_wr_s |=> onboard_program_image_out[7:0] == $past(pwdata[7:0])
      && $stable(onboard_program_image_out[15:8])) else $error("byte lane");
   unmapped_a: assert property (rd && paddr[11:8] == 4'hF |-> pslverr && !prdata) else $error("unmapped");
endmodule : image_mapper_props
bind image_mapper image_mapper_props #(.NUM_SLOTS(NUM_SLOTS), .IMG_WORDS(IMG_WORDS)) i_props (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .onboard_program_image_in,
   .onboard_program_image_out);
`default_nettype wire

// ### image_master.sv
// Partner model: an APB master that reads and writes the process images.
`default_nettype none
module image_master (
   input wire logic pclk,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb
);
   timeunit 1ns;
   timeprecision 1ps;
   // The bus is idle from time zero.
   initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
   // One transfer, held until pready is sampled high; on release paddr and pwdata are inverted while pwrite and pstrb keep their value.
   task automatic xfer(logic w, logic [11:0] a, logic [15:0] d, logic [3:0] s, output logic [31:0] r, output logic e);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'h2, w, a, 16'h0, d, s};
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      {psel, penable, paddr, pwdata} <= {2'h0, ~a, ~pwdata};
   endtask : xfer
endmodule : image_master
`default_nettype wire

// ### tb_image_mapper.sv
// Self-checking testbench of the image mapper.
`default_nettype none
module tb_image_mapper import image_mapper_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [3:0] pstrb;
   logic [31:0] pwdata, prdata, r, r0, lfsr = 32'hFF45216D;
   logic [1:0] blk = 2'h0;
   logic [15:0] oimg [16] = '{default: 16'h0};
   logic [7:0] mask, channel_out [8];
   field_pins_type field_in [8] = '{default: '0};
   slot_kind_type kinds [8] = '{KIND_DI2, KIND_DI1_DIAG, KIND_DI2_DIAG, KIND_DO1_IN, KIND_DI8, KIND_DI2_ACK,
      KIND_DI4, KIND_DO8};
   int fails = 0, compares = 0, ai, ao;
   // Clock of 4 ns period.
   always #2 pclk = ~pclk;
   image_master i_master (.pclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb);
   image_mapper i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .field_in, .channel_out, .onboard_program_image_in(), .onboard_program_image_out());
   // Next stimulus value from the shift register.
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd
   // Expected two words of digital inputs for the slot layout above, given the blocked ack channels.
   function automatic logic [31:0] exp_in(logic [1:0] b);
      return {6'h00, field_in[6].state[3:0], b, field_in[5].state[1:0] & ~b, field_in[4].state, 1'h0,
         field_in[3].manual, field_in[2].fault, field_in[2].state[1:0], field_in[1].fault[0], field_in[1].state[0],
         field_in[0].state[1:0]};
   endfunction : exp_in
   task automatic check(logic [31:0] seen, logic [31:0] want);
      compares++;
      if (seen !== want) begin
         fails++;
         $display("MISMATCH %0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic summarize();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   task automatic wr(logic [11:0] a, logic [15:0] d, logic [3:0] s = 4'h3);
      i_master.xfer(1'h1, a, d, s, r, e);
   endtask : wr
   task automatic rd(logic [11:0] a);
      i_master.xfer(1'h0, a, 16'h0, 4'h0, r, e);
   endtask : rd
   // Watchdog far beyond the expected run.
   initial begin
      #80000;
      fails++;
      summarize();
   end
   // Reset, then layouts with random analog sizes under random field and output traffic.
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      rd(12'hF00);
      check({r[30:0], e}, 32'h1);
      rd(12'h002);
      check({31'h0, e}, 32'h1);
      for (int s = 0; s < 7; s++) wr(12'(512 + 4 * s), 16'(kinds[s]));
      for (int p = 0; p < 12; p++) begin
         kinds[7] = slot_kind_type'(KIND_DO2 + p % 3);
         mask = p % 3 == 0 ? 8'h03 : p % 3 == 1 ? 8'h0F : 8'hFF;
         ai = p ? rnd() % 3 : 0;
         ao = p ? rnd() % 3 : 0;
         wr(12'h21C, 16'(kinds[7]));
         wr(12'h300, 16'(ai));
         wr(12'h304, 16'(ao));
         @(posedge pclk);
         blk = field_in[5].fault | blk & ~oimg[ao][5:4];
         foreach (field_in[i]) field_in[i] <= 11'(rnd());
         repeat (3) @(posedge pclk);
         blk = field_in[5].fault | blk & ~oimg[ao][5:4];
         oimg[ao] = 16'(rnd()) & 16'hFFF3;
         wr(12'(256 + 4 * ao), oimg[ao]);
         repeat (3) @(posedge pclk);
         blk = field_in[5].fault | blk & ~oimg[ao][5:4];
         rd(12'(4 * ai));
         r0 = r;
         rd(12'(4 * ai + 4));
         check({r[15:0], r0[15:0]}, exp_in(blk));
         check({channel_out[7], channel_out[3], 16'h0}, {oimg[ao][13:6] & mask, 7'h0, oimg[ao][0], 16'h0});
      end
      wr(12'h100, 16'h1234);
      wr(12'h100, 16'hABCD, 4'h1);
      rd(12'h100);
      check(r, 32'h12CD);
      summarize();
   end
endmodule : tb_image_mapper
`default_nettype wire
